// ===== src/smbw_slave.sv
// SMBus slave front end: address match, command decode, register writes and timeouts
`timescale 1ns/1ps
`default_nettype none
module smbw_slave
    import smbw_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = TOUT_CYC
)(
    // System clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus pins
    input wire logic scl_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Address select, already resolved from the tri-level pin
    input wire logic [1:0] addr_sel,
    // Register write port
    output logic reg_wr,
    output logic [7:0] reg_waddr,
    output logic [7:0] reg_wdata,
    // Read side hand-off
    output logic [7:0] rd_ptr,
    output logic [7:0] rd_len,
    output logic rd_active,
    output logic rd_byte_done,
    // Status
    output logic tout_evt
);

    // Link domain: sample each bit on the rising bus clock, flag it by toggling
    logic lbit_q;
    logic ltog_q;

    always_ff @(posedge scl_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lbit_q <= 1'b0;
            ltog_q <= 1'b0;
        end
        else
        begin
            lbit_q <= sda_i;
            ltog_q <= ~ltog_q;
        end
    end

    // Synchronisers; lbit_q stays stable after its toggle lands until the next rising bus clock
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [1:0] tog_s_q;
    logic [1:0] sel_m_q;
    logic [1:0] sel_s_q;
    logic scl_d_q;
    logic sda_d_q;
    logic tog_d_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            tog_s_q <= 2'h0;
            sel_m_q <= SEL_RST;
            sel_s_q <= SEL_RST;
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            tog_d_q <= 1'b0;
        end
        else
        begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            tog_s_q <= {tog_s_q[0], ltog_q};
            sel_m_q <= addr_sel;
            sel_s_q <= sel_m_q;
            scl_d_q <= scl_s_q[1];
            sda_d_q <= sda_s_q[1];
            tog_d_q <= tog_s_q[1];
        end
    end

    // Bus events
    wire scl_h = scl_s_q[1];
    wire sda_h = sda_s_q[1];
    wire scl_fall = scl_d_q && !scl_h;
    wire start_evt = scl_h && scl_d_q && sda_d_q && !sda_h;
    wire stop_evt = scl_h && scl_d_q && !sda_d_q && sda_h;
    wire bit_evt = tog_s_q[1] ^ tog_d_q;

    // Per-line timeouts
    logic [1:0] line_low;
    logic [1:0] line_exp;
    assign line_low = {!sda_h, !scl_h};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_tout
            smbw_timeout #(
                .TOUT_CYCLES(TOUT_CYCLES)
            ) u_tout (
                .clk(clk),
                .rst_n(rst_n),
                .line_low(line_low[gi]),
                .expired(line_exp[gi])
            );
        end
    endgenerate

    wire tout_any = |line_exp;

    // Engine registers
    smbw_state_t state_q;
    smbw_state_t state_d;
    logic [3:0] bitcnt_q;
    logic [7:0] sh_q;
    logic [7:0] byte_q;
    logic acked_q;
    logic ack_pend_q;
    logic sda_oe_q;
    logic [7:0] waddr_q;
    logic [7:0] waddr_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] len_q;
    logic [7:0] len_d;
    logic proc_q;
    logic proc_d;
    logic wr_q;
    logic wr_d;
    logic [7:0] wdata_q;
    logic rdact_q;
    logic rddone_q;
    logic lock_q;
    logic [1:0] lo_q;
    logic tout_q;

    // Byte assembly and decode
    wire [7:0] byte_w = {sh_q[6:0], lbit_q};
    wire byte_full = bit_evt && (bitcnt_q == BIT_LAST_DATA);
    wire ack_evt = bit_evt && (bitcnt_q == BIT_ACK);
    wire [1:0] my_lo = lock_q ? lo_q : sel_s_q;
    wire addr_hit = (byte_w[7:3] == SLV_ADDR_HI) && (byte_w[2:1] == my_lo);
    wire wr_state = (state_q == S_CMD) || (state_q == S_COUNT) || (state_q == S_FIRST)
                    || (state_q == S_RDLEN) || (state_q == S_DATA) || (state_q == S_EXTRA);
    wire ack_ok = (state_q == S_ADDR) ? addr_hit : wr_state;
    wire in_space = (waddr_q <= REG_LAST);
    wire [7:0] waddr_inc = (waddr_q == REG_SAT) ? REG_SAT : waddr_q + 8'h01;
    wire fix_cmd = smbw_fix_hit(byte_q);
    wire [3:0] fix_i = smbw_fix_idx(byte_q);
    wire [7:0] fix_addr = fix_cmd ? FIX_ADDR[fix_i] : BYTE_RST;
    wire [7:0] fix_len = fix_cmd ? FIX_LEN[fix_i] : LEN_NONE;

    // Only timeout, START and STOP restart the engine; rst_n is power-on only
    always_comb
    begin
        state_d = state_q;
        waddr_d = waddr_q;
        ptr_d = ptr_q;
        len_d = len_q;
        proc_d = proc_q;
        wr_d = 1'b0;
        if (tout_any)
            state_d = S_IDLE;
        else if (start_evt)
            state_d = S_ADDR;
        else if (stop_evt)
            state_d = S_IDLE;
        else if (ack_evt)
        begin
            case (state_q)
                S_ADDR:
                    if (!acked_q)
                        state_d = S_IGNORE;
                    else if (byte_q[0])
                        state_d = S_READ;
                    else
                        state_d = S_CMD;
                S_CMD:
                    if (byte_q == CMD_BLK_WR)
                    begin
                        proc_d = 1'b0;
                        state_d = S_COUNT;
                    end
                    else if (byte_q == CMD_PROC)
                    begin
                        proc_d = 1'b1;
                        state_d = S_COUNT;
                    end
                    else if (fix_cmd)
                    begin
                        ptr_d = fix_addr;
                        len_d = fix_len;
                        state_d = S_EXTRA;
                    end
                    else
                    begin
                        ptr_d = byte_q;
                        len_d = LEN_NONE;
                        waddr_d = byte_q;
                        state_d = S_DATA;
                    end
                S_COUNT:
                    state_d = S_FIRST;
                S_FIRST:
                begin
                    waddr_d = byte_q;
                    ptr_d = byte_q;
                    if (proc_q)
                        state_d = S_RDLEN;
                    else
                    begin
                        len_d = LEN_NONE;
                        state_d = S_DATA;
                    end
                end
                S_RDLEN:
                begin
                    len_d = byte_q;
                    state_d = S_EXTRA;
                end
                S_DATA:
                begin
                    // No byte limit: keep committing until STOP while the address is inside the register space
                    wr_d = in_space;
                    waddr_d = waddr_inc;
                end
                S_READ:
                    if (lbit_q)
                        state_d = S_IGNORE;
                default:
                    state_d = state_q;
            endcase
        end
    end

    // Bit counter and shift register; a START or STOP drops the partial byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitcnt_q <= BIT_ZERO;
            sh_q <= BYTE_RST;
            byte_q <= BYTE_RST;
            acked_q <= 1'b0;
        end
        else if (start_evt || stop_evt || tout_any)
        begin
            bitcnt_q <= BIT_ZERO;
            acked_q <= 1'b0;
        end
        else if (bit_evt)
        begin
            bitcnt_q <= ack_evt ? BIT_ZERO : bitcnt_q + 4'h1;
            sh_q <= byte_w;
            if (byte_full)
            begin
                byte_q <= byte_w;
                acked_q <= ack_ok;
            end
        end
    end

    // Acknowledge drive: pull low from the fall after bit 8 to the fall after bit 9
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (start_evt || stop_evt || tout_any)
        begin
            ack_pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (byte_full)
            ack_pend_q <= ack_ok;
        else if (scl_fall)
        begin
            sda_oe_q <= ack_pend_q;
            ack_pend_q <= 1'b0;
        end
    end

    // Engine state and outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            waddr_q <= REG_FIRST;
            ptr_q <= REG_FIRST;
            len_q <= LEN_NONE;
            proc_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= BYTE_RST;
            rdact_q <= 1'b0;
            rddone_q <= 1'b0;
            tout_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            waddr_q <= waddr_d;
            ptr_q <= ptr_d;
            len_q <= len_d;
            proc_q <= proc_d;
            wr_q <= wr_d;
            if (wr_d)
                wdata_q <= byte_q;
            rdact_q <= (state_d == S_READ);
            rddone_q <= ack_evt && (state_q == S_READ) && !start_evt && !stop_evt && !tout_any;
            tout_q <= tout_any;
        end
    end

    // Address latch: first matching transaction fixes the low bits until power-down
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_q <= 1'b0;
            lo_q <= SEL_RST;
        end
        else if (byte_full && (state_q == S_ADDR) && addr_hit && !lock_q)
        begin
            lock_q <= 1'b1;
            lo_q <= sel_s_q;
        end
    end

    // Register write port stands one cycle with the address before its increment
    logic [7:0] wa_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wa_q <= REG_FIRST;
        else if (wr_d)
            wa_q <= waddr_q;
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign reg_wr = wr_q;
    assign reg_waddr = wa_q;
    assign reg_wdata = wdata_q;
    assign rd_ptr = ptr_q;
    assign rd_len = len_q;
    assign rd_active = rdact_q;
    assign rd_byte_done = rddone_q;
    assign tout_evt = tout_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wr_range_a: assert property (reg_wr |-> reg_waddr <= REG_LAST)
        else $error("write outside register space");
    addr_sat_a: assert property (ack_evt && state_q == S_DATA && waddr_q == REG_SAT && !tout_any
        && !start_evt && !stop_evt |=> waddr_q == REG_SAT)
        else $error("block write address wrapped");
    tout_idle_a: assert property (tout_any |=> state_q == S_IDLE ##1 !sda_oe)
        else $error("timeout did not idle the engine");
    abort_nowr_a: assert property ((start_evt || stop_evt) && !ack_evt |=> !reg_wr)
        else $error("partial byte committed");
    start_init_a: assert property (start_evt && !tout_any |=> state_q == S_ADDR && bitcnt_q == BIT_ZERO)
        else $error("start did not reinitialise");
    cmd_f0_a: assert property (ack_evt && state_q == S_CMD && byte_q == CMD_BLK_WR && !tout_any
        && !start_evt && !stop_evt |=> state_q == S_COUNT ##1 !reg_wr)
        else $error("block write command misdecoded");
    fix_f2_a: assert property (ack_evt && state_q == S_CMD && byte_q == CMD_FIX_FIRST && !tout_any
        && !start_evt && !stop_evt |=> rd_ptr == 8'h40 && rd_len == 8'h08)
        else $error("fixed block decode wrong");
    ptr_hold_a: assert property (rd_active && $stable(rd_active) |-> $stable(rd_ptr))
        else $error("pointer moved during read");
    ack_slot_a: assert property ($rose(sda_oe) |-> bitcnt_q == BIT_ACK && acked_q)
        else $error("acknowledge out of slot");

    wr_blk_c: cover property (state_q == S_DATA && proc_q == 1'b0 && reg_wr);
    fix_cmd_c: cover property (state_q == S_EXTRA && len_q == 8'h20);
    tout_c: cover property (tout_evt);
    rd_done_c: cover property (rd_byte_done);

endmodule
`default_nettype wire

// ===== src/smbw_pkg.sv
// Constants, types and decode helpers shared by the SMBus slave write/command logic
package smbw_pkg;

    // System clock and bus timeout
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TOUT_US = 25_000;
    localparam int unsigned TOUT_CYC = TOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TOUT_W = 20;

    // Slave address and register space
    localparam logic [4:0] SLV_ADDR_HI = 5'h0b;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] REG_FIRST = 8'h00;
    localparam logic [7:0] REG_LAST = 8'hef;
    localparam logic [7:0] REG_SAT = 8'hff;

    // Block command codes
    localparam logic [7:0] CMD_BLK_WR = 8'hf0;
    localparam logic [7:0] CMD_PROC = 8'hf1;
    localparam logic [7:0] CMD_FIX_FIRST = 8'hf2;
    localparam logic [7:0] CMD_FIX_LAST = 8'hfd;
    localparam int unsigned FIX_N = 12;
    localparam logic [7:0] FIX_ADDR [FIX_N] = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6e,
                                                8'h78, 8'h90, 8'hb4, 8'hc8, 8'hd0, 8'he5};
    localparam logic [7:0] FIX_LEN [FIX_N] = '{8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08,
                                               8'h0c, 8'h20, 8'h08, 8'h08, 8'h10, 8'h09};

    // Bit positions within a nine-clock byte slot
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] LEN_NONE = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_CMD, S_COUNT, S_FIRST, S_RDLEN, S_DATA, S_EXTRA, S_READ, S_IGNORE
    } smbw_state_t;

    function automatic logic smbw_fix_hit(input logic [7:0] cmd);
        return (cmd >= CMD_FIX_FIRST) && (cmd <= CMD_FIX_LAST);
    endfunction

    function automatic logic [3:0] smbw_fix_idx(input logic [7:0] cmd);
        logic [7:0] d;
        d = cmd - CMD_FIX_FIRST;
        return d[3:0];
    endfunction

endpackage

// ===== src/smbw_timeout.sv
// Low-level timeout detector for one bus line
`timescale 1ns/1ps
`default_nettype none
module smbw_timeout
    import smbw_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = TOUT_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line state, already synchronised
    input wire logic line_low,
    // One-cycle pulse when the low period passes the limit
    output logic expired
);

    localparam logic [TOUT_W-1:0] LIMIT = TOUT_W'(TOUT_CYCLES - 1);

    logic [TOUT_W-1:0] cnt_q;
    logic [TOUT_W-1:0] cnt_d;
    logic hit_q;
    logic fired_q;
    wire at_limit = (cnt_q == LIMIT);

    // Saturate so one long low period gives a single pulse
    assign cnt_d = !line_low ? '0 : (at_limit ? cnt_q : cnt_q + TOUT_W'(1));
    assign expired = hit_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            hit_q <= 1'b0;
            fired_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            hit_q <= line_low && at_limit && !fired_q;
            fired_q <= line_low && at_limit;
        end
    end

endmodule
`default_nettype wire

// ===== dv/smbw_host.sv
// Behavioural SMBus host: drives the bus clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module smbw_host
#(
    parameter int H = 8
)(
    // Resolved data line
    input wire logic sda,
    // Bus clock and data pull-down
    output logic scl,
    output logic sda_low
);
    logic tck = 1'b0;

    // 48 ns link timebase; the bus clock stands high between frames
    always #24 tck = ~tck;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge tck);
    endtask

    // Data moves only mid-way through the low phase
    task automatic pulse(input logic b, output logic smp);
        ticks(H / 2);
        sda_low = ~b;
        ticks(H / 2);
        scl = 1'b1;
        ticks(H / 2);
        smp = sda;
        ticks(H / 2);
        scl = 1'b0;
    endtask

    // Long release first, so a slow device ACK cannot look like a STOP
    task automatic start;
        sda_low = 1'b0;
        ticks(H);
        scl = 1'b1;
        ticks(H);
        sda_low = 1'b1;
        ticks(H);
        scl = 1'b0;
    endtask

    task automatic stop;
        sda_low = 1'b1;
        ticks(H / 2);
        scl = 1'b1;
        ticks(H);
        sda_low = 1'b0;
        ticks(H);
    endtask

    // Holding data low with the clock high reads as a START, then a stuck line
    task automatic hold_sda(input int n);
        sda_low = 1'b1;
        ticks(n);
        sda_low = 1'b0;
        ticks(H);
    endtask

    // MSB first; only a whole byte gets its ninth slot, where mack pulls low
    task automatic xfer(input logic [7:0] d, input int n, input logic mack, output logic ack);
        logic smp;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--)
            pulse(d[i], smp);
        if (n == 8)
        begin
            pulse(~mack, smp);
            ack = ~smp;
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/test_smbus_slave_write_and_command_logic.sv
// Self-checking bench for the SMBus slave write and command logic
`timescale 1ns/1ps
`default_nettype none
module test_smbus_slave_write_and_command_logic
    import smbw_pkg::*;
;

    localparam logic [7:0] AW = 8'h5a;
    localparam logic [7:0] AR = 8'h5b;
    logic [7:0] nack_addr [3] = '{8'h5c, 8'h3a, 8'h18};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr_sel = 2'h1;
    logic scl, m_low, sda_o, sda_oe, reg_wr, rd_active, rd_byte_done, tout_evt, ack;
    logic [7:0] reg_waddr, reg_wdata, rd_ptr, rd_len, s, d;
    wire logic sda = ~(m_low | (sda_oe & ~sda_o));
    int fails = 0;
    int tests_run = 0;
    int n_done = 0;
    int n_tout = 0;
    logic [15:0] got_q[$];
    logic [15:0] exp_q[$];

    always #25 clk = ~clk;

    // Short timeout, yet far above any low run that random data can make on the line
    smbw_slave #(.TOUT_CYCLES(1000)) i_smbw_slave (.clk(clk), .rst_n(rst_n), .scl_clk(scl), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_wr(reg_wr),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .rd_ptr(rd_ptr), .rd_len(rd_len),
        .rd_active(rd_active), .rd_byte_done(rd_byte_done), .tout_evt(tout_evt));

    smbw_host #(.H(8)) i_smbw_host (.sda(sda), .scl(scl), .sda_low(m_low));

    always @(posedge clk)
    begin
        if (reg_wr === 1'b1)
            got_q.push_back({reg_waddr, reg_wdata});
        if (rd_byte_done === 1'b1)
            n_done++;
        if (tout_evt === 1'b1)
            n_tout++;
    end

    function automatic logic [7:0] blk_addr(input logic [7:0] st, input int k);
        return (int'(st) + k > 255) ? REG_SAT : 8'(int'(st) + k);
    endfunction

    function automatic logic [15:0] fix_exp(input int i);
        logic [15:0] t [12] = '{16'h4008, 16'h4808, 16'h5006, 16'h5610, 16'h6704, 16'h6e08,
                                16'h780c, 16'h9020, 16'hb408, 16'hc808, 16'hd010, 16'he509};
        return t[i];
    endfunction

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write log is compared once the last slot has settled
    task automatic chk_wr;
        repeat (20) @(posedge clk);
        chk(16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size())
                chk(got_q[i], exp_q[i]);
        got_q = {};
        exp_q = {};
    endtask

    task automatic wb(input logic [7:0] b, input logic e);
        i_smbw_host.xfer(b, 8, 1'b0, ack);
        chk({15'h0, ack}, {15'h0, e});
    endtask

    task automatic seq(input logic [7:0] q[$]);
        i_smbw_host.start();
        foreach (q[i])
            wb(q[i], 1'b1);
        i_smbw_host.stop();
        chk_wr();
    endtask

    // k random bytes from register st; the block command adds a random, ignored count
    task automatic blk(input logic [7:0] cmd, input logic [7:0] st, input int k);
        logic [7:0] q[$];
        logic [7:0] v;
        q = {AW};
        if (cmd == CMD_BLK_WR)
            q = {q, cmd, 8'($urandom)};
        q.push_back(st);
        for (int j = 0; j < k; j++)
        begin
            v = 8'($urandom);
            q.push_back(v);
            if (blk_addr(st, j) <= REG_LAST)
                exp_q.push_back({blk_addr(st, j), v});
        end
        seq(q);
    endtask

    task automatic rd(input int k);
        i_smbw_host.start();
        wb(AR, 1'b1);
        repeat (8) @(posedge clk);
        chk({15'h0, rd_active}, 16'h1);
        i_smbw_host.xfer(8'hff, 8, 1'b1, ack);
        i_smbw_host.xfer(8'hff, k, 1'b0, ack);
        i_smbw_host.stop();
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'he6d3));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        blk(8'h00, 8'($urandom_range(0, 239)), 1);
        blk(8'h00, 8'hef, 2);
        blk(8'h00, 8'($urandom_range(0, 237)), 2);
        blk(8'h00, 8'($urandom_range(0, 200)), 12);
        blk(CMD_BLK_WR, 8'he0, 34);
        blk(CMD_BLK_WR, 8'($urandom_range(0, 230)), 3);
        s = 8'($urandom_range(0, 239));
        blk(8'h00, s, 0);
        chk({rd_ptr, rd_len}, {s, LEN_NONE});
        n_done = 0;
        rd(8);
        rd(8);
        rd(4);
        repeat (10) @(posedge clk);
        chk(16'(n_done), 16'h5);
        chk({rd_ptr, rd_len}, {s, LEN_NONE});
        for (int c = 0; c < 12; c++)
        begin
            seq({AW, 8'(8'hf2 + c), 8'($urandom)});
            chk({rd_ptr, rd_len}, fix_exp(c));
        end
        d = 8'($urandom_range(1, 32));
        seq({AW, CMD_PROC, 8'h02, s, d});
        chk({rd_ptr, rd_len}, {s, d});
        seq({AW, CMD_PROC});
        chk({rd_ptr, rd_len}, {s, d});
        d = 8'($urandom);
        i_smbw_host.start();
        wb(AW, 1'b1);
        wb(s, 1'b1);
        i_smbw_host.xfer(d, 5, 1'b0, ack);
        i_smbw_host.stop();
        chk_wr();
        i_smbw_host.start();
        wb(AW, 1'b1);
        wb(s, 1'b1);
        i_smbw_host.xfer(d, 3, 1'b0, ack);
        exp_q.push_back({s, d});
        seq({AW, s, d});
        @(posedge clk);
        addr_sel <= 2'h2;
        seq({AW});
        foreach (nack_addr[i])
        begin
            i_smbw_host.start();
            wb(nack_addr[i], 1'b0);
            i_smbw_host.stop();
        end
        n_tout = 0;
        i_smbw_host.start();
        wb(AW, 1'b1);
        // Ones only, so the data line stays high and just the clock line times out
        i_smbw_host.xfer(8'hff, 3, 1'b0, ack);
        i_smbw_host.ticks(1100);
        chk({n_tout[14:0], sda_oe}, 16'h2);
        i_smbw_host.stop();
        i_smbw_host.hold_sda(1100);
        chk(16'(n_tout), 16'h2);
        exp_q.push_back({s, d});
        seq({AW, s, d});
        wrap_up();
    end
endmodule
`default_nettype wire
